/* hdl/lpgm_defs.svh */
`ifndef LPGM_DEFS_SVH
`define LPGM_DEFS_SVH
// register map (byte addresses, one word each)
`define LPGM_CTRL_OFS      8'h00
`define LPGM_STATUS_OFS    8'h04
`define LPGM_ERROR_OFS     8'h08
`define LPGM_TXCNT_OFS     8'h0c
`define LPGM_RXCNT_OFS     8'h10
// control fields
`define LPGM_CTRL_RESTART  0
`define LPGM_CTRL_SIMPLEX  1
`define LPGM_CTRL_EXTALIGN 2
`define LPGM_CTRL_RECFG    3
// status fields
`define LPGM_ST_GENBUSY    0
`define LPGM_ST_GENDONE    1
`define LPGM_ST_MONBUSY    2
`define LPGM_ST_MONDONE    3
`define LPGM_ST_MONFAIL    4
`define LPGM_ST_LOCKED     5
`define LPGM_ST_ALIGNED    6
// lock-state values
`define LPGM_MUBITS_INIT   8'h00
`define LPGM_LANESTAT_INIT 12'hfff
`define LPGM_INTFSTAT_INIT 1'b1
// pipeline depth on external signals
`define LPGM_SYNC_STAGES   3
`endif

/* hdl/lpgm_pkg.sv */
package lpgm_pkg;
    typedef enum logic [3:0] {
        GEN_IDLE, GEN_LOCK, GEN_WAIT_ALIGN, GEN_ENABLE, GEN_INIT,
        GEN_TX0, GEN_TX1, GEN_HOLD, GEN_DONE, GEN_RESTART
    } lpgm_gen_state_t;
    typedef enum logic [3:0] {
        MON_IDLE, MON_LOCK, MON_WAIT_ALIGN, MON_ENABLE, MON_INIT,
        MON_RECEIVE, MON_DONE, MON_REPORT, MON_RESTART
    } lpgm_mon_state_t;
endpackage

/* hdl/lpgm_packet_gen_mon.sv */
// Notes on behaviour
// [RL1] generator idles until reset complete
// [RL2] lock state: fixed control values, init low
// [RL3] wait alignment, or external aligned in simplex
// [RL4] enable state sets transmit enable
// [RL5] init until init-complete and ready
// [RL6] first transmit state: start packets, count
// [RL7] ready low in transmit goes hold
// [RL8] second transmit state finishes packet body
// [RL9] hold resumes in originating transmit state
// [RL10] done state raises transmit-done flag
// [RL11] restart clears busy, back to idle
// [RL12] external logic asserts aligned in simplex
// [RL13] monitor idles until reset complete
// [RL14] monitor lock sets locked and busy
// [RL15] wait alignment then enable receive
// [RL16] per-segment data, channel checks; empty count
// [RL17] sticky error until reset; done after all
// [RL18] monitor done sets receive-done flag
// [RL19] report done and failed from error
// [RL20] restart clears, waits registered restart request
// [RL21] reconfig reset high during port access
// [RL22] external signals pass three register stages
// [RL23] restart only while both not busy
// [RL24] generator busy from leaving idle to restart
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "lpgm_defs.svh"
module lpgm_packet_gen_mon #(
    parameter int NUM_PKTS  = 16,
    parameter int PKT_BEATS = 4,
    parameter int SEGS      = 4,
    parameter int SEG_W     = 128
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [7:0]            haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // core status
    input  wire logic                  resetDone,
    input  wire logic                  statRxAligned,
    input  wire logic                  txRdyOut,
    // core transmit control and segmented bus
    output logic                       ctlTxEnable,
    output logic      [7:0]            ctlTxMubits,
    output logic      [11:0]           ctlTxLaneStat,
    output logic                       ctlTxIntfStat,
    output logic                       coreReconfigReset,
    output logic      [SEGS*SEG_W-1:0] txData,
    output logic      [SEGS-1:0]       txEna,
    output logic      [SEGS-1:0]       txSop,
    output logic      [SEGS-1:0]       txEop,
    output logic      [SEGS*4-1:0]     txMty,
    output logic      [SEGS*11-1:0]    txChan,
    // core receive segmented bus
    output logic                       ctlRxEnable,
    input  wire logic [SEGS*SEG_W-1:0] rxData,
    input  wire logic [SEGS-1:0]       rxEna,
    input  wire logic [SEGS-1:0]       rxSop,
    input  wire logic [SEGS-1:0]       rxEop,
    input  wire logic [SEGS*4-1:0]     rxMty,
    input  wire logic [SEGS*11-1:0]    rxChan
);
    ////////////////////////////////////////////////////////////////////////////
    // three-stage input registering
    // per segment: data, ena, sop, eop, four mty bits and eleven channel bits
    localparam int INW = 3 + SEGS * (SEG_W + 18);
    logic [INW-1:0] inPipe [`LPGM_SYNC_STAGES];
    wire  [INW-1:0] inRaw = {resetDone, statRxAligned, txRdyOut,
                             rxData, rxEna, rxSop, rxEop, rxMty, rxChan};
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < `LPGM_SYNC_STAGES; i++)
                inPipe[i] <= '0;
        end
        else
        begin
            inPipe[0] <= inRaw; // RL22
            for (int i = 1; i < `LPGM_SYNC_STAGES; i++)
                inPipe[i] <= inPipe[i-1];
        end
    end
    wire                   rDone   = inPipe[2][INW-1];
    wire                   rAlign  = inPipe[2][INW-2];
    wire                   rRdy    = inPipe[2][INW-3];
    wire [SEGS*SEG_W-1:0]  rData   = inPipe[2][SEGS*18 +: SEGS*SEG_W];
    wire [SEGS-1:0]        rEna    = inPipe[2][SEGS*17 +: SEGS];
    wire [SEGS-1:0]        rEop    = inPipe[2][SEGS*15 +: SEGS];
    wire [SEGS*4-1:0]      rMty    = inPipe[2][SEGS*11 +: SEGS*4];
    wire [SEGS*11-1:0]     rChan   = inPipe[2][0 +: SEGS*11];

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait states, always OKAY
    logic        wrPend_reg;
    logic [7:0]  wrAddr_reg;
    logic [3:0]  ctrl_reg;
    logic [2:0]  restartPipe_reg;
    logic [15:0] txCnt_reg;
    logic [15:0] rxCnt_reg;
    logic        genBusy_reg;
    logic        genDone_reg;
    logic        monBusy_reg;
    logic        monDone_reg;
    logic        monFail_reg;
    logic        monLocked_reg;
    logic [SEGS*2:0] errBits_reg;
    wire   addrOk   = hsel && hready && htrans[1];
    wire   restartPulse = wrPend_reg && (wrAddr_reg == `LPGM_CTRL_OFS)
                          && hwdata[`LPGM_CTRL_RESTART];
    wire   restart_req_sync = restartPipe_reg[2];
    wire [31:0] statusWord = {25'h0, rAlign, monLocked_reg, monFail_reg,
                              monDone_reg, monBusy_reg, genDone_reg, genBusy_reg};
    wire [31:0] rdMux =
        (haddr == `LPGM_CTRL_OFS)   ? {28'h0, ctrl_reg} :
        (haddr == `LPGM_STATUS_OFS) ? statusWord :
        (haddr == `LPGM_ERROR_OFS)  ? 32'(errBits_reg) :
        (haddr == `LPGM_TXCNT_OFS)  ? {16'h0, txCnt_reg} :
        (haddr == `LPGM_RXCNT_OFS)  ? {16'h0, rxCnt_reg} : 32'h0;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hrdata     <= 32'h0;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            ctrl_reg   <= 4'h0;
            restartPipe_reg <= 3'h0;
        end
        else
        begin
            wrPend_reg <= addrOk && hwrite;
            wrAddr_reg <= haddr;
            // no wait states and no error responses: both are held constant
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            if (addrOk && !hwrite)
                hrdata <= rdMux;
            if (wrPend_reg && wrAddr_reg == `LPGM_CTRL_OFS)
                ctrl_reg <= {hwdata[3:1], 1'b0};
            // restart only taken while idle; a request during busy is dropped
            restartPipe_reg <= {restartPipe_reg[1:0],
                                restartPulse && !genBusy_reg && !monBusy_reg}; // RL22 RL23
        end
    end
    wire simplexTx = ctrl_reg[`LPGM_CTRL_SIMPLEX];
    wire extAlign  = ctrl_reg[`LPGM_CTRL_EXTALIGN];

    ////////////////////////////////////////////////////////////////////////////
    // packet generator
    lpgm_pkg::lpgm_gen_state_t gState_reg, gState_next, gHeld_reg;
    logic [7:0] beat_reg;
    logic       initDone_reg;
    wire  alignOk  = simplexTx ? extAlign : rAlign; // RL3 RL12
    wire  lastBeat = (beat_reg == 8'(PKT_BEATS - 1));
    wire  allSent  = (txCnt_reg == 16'(NUM_PKTS));
    always_comb
    begin
        gState_next = gState_reg;
        unique case (gState_reg)
            lpgm_pkg::GEN_IDLE:       if (rDone) gState_next = lpgm_pkg::GEN_LOCK; // RL1
            lpgm_pkg::GEN_LOCK:       gState_next = lpgm_pkg::GEN_WAIT_ALIGN;
            lpgm_pkg::GEN_WAIT_ALIGN: if (alignOk) gState_next = lpgm_pkg::GEN_ENABLE; // RL3
            lpgm_pkg::GEN_ENABLE:     gState_next = lpgm_pkg::GEN_INIT;
            lpgm_pkg::GEN_INIT:       if (initDone_reg && rRdy) gState_next = lpgm_pkg::GEN_TX0; // RL5
            lpgm_pkg::GEN_TX0:
                if (allSent) gState_next = lpgm_pkg::GEN_DONE; // RL6
                else if (!rRdy) gState_next = lpgm_pkg::GEN_HOLD; // RL7
                else gState_next = lpgm_pkg::GEN_TX1; // RL6
            lpgm_pkg::GEN_TX1:
                if (!rRdy) gState_next = lpgm_pkg::GEN_HOLD; // RL7
                else if (lastBeat) gState_next = lpgm_pkg::GEN_TX0; // RL8
            lpgm_pkg::GEN_HOLD:       if (rRdy) gState_next = gHeld_reg; // RL9
            lpgm_pkg::GEN_DONE:       gState_next = lpgm_pkg::GEN_RESTART; // RL10
            lpgm_pkg::GEN_RESTART:    gState_next = lpgm_pkg::GEN_IDLE; // RL11
            default:                  gState_next = lpgm_pkg::GEN_IDLE;
        endcase
    end
    // a beat is sent only when the state does not stall on ready
    wire sendSop  = (gState_reg == lpgm_pkg::GEN_TX0) && rRdy && !allSent;
    wire sendBody = (gState_reg == lpgm_pkg::GEN_TX1) && rRdy;
    wire [SEG_W-1:0] pattern = {(SEG_W/16){txCnt_reg}};
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gState_reg <= lpgm_pkg::GEN_IDLE;
            gHeld_reg  <= lpgm_pkg::GEN_TX0;
            genBusy_reg <= 1'b0;
            genDone_reg <= 1'b0;
            initDone_reg <= 1'b0;
            beat_reg   <= 8'h00;
            txCnt_reg  <= 16'h0;
            ctlTxEnable <= 1'b0;
            ctlTxMubits <= 8'h00;
            ctlTxLaneStat <= 12'h000;
            ctlTxIntfStat <= 1'b0;
            txData <= '0;
            txEna  <= '0;
            txSop  <= '0;
            txEop  <= '0;
            txMty  <= '0;
            txChan <= '0;
        end
        else
        begin
            gState_reg <= gState_next;
            if (gState_next == lpgm_pkg::GEN_HOLD && gState_reg != lpgm_pkg::GEN_HOLD)
                gHeld_reg <= gState_reg; // RL9
            if (gState_reg == lpgm_pkg::GEN_IDLE && rDone)
                genBusy_reg <= 1'b1; // RL24
            else if (gState_reg == lpgm_pkg::GEN_RESTART)
                genBusy_reg <= 1'b0; // RL11 RL24
            if (gState_reg == lpgm_pkg::GEN_LOCK)
            begin
                ctlTxEnable   <= 1'b0; // RL2
                ctlTxMubits   <= `LPGM_MUBITS_INIT;
                ctlTxLaneStat <= `LPGM_LANESTAT_INIT;
                ctlTxIntfStat <= `LPGM_INTFSTAT_INIT;
                initDone_reg  <= 1'b0;
                genDone_reg   <= 1'b0;
            end
            if (gState_reg == lpgm_pkg::GEN_ENABLE)
                ctlTxEnable <= 1'b1; // RL4
            if (gState_reg == lpgm_pkg::GEN_INIT)
            begin
                initDone_reg <= 1'b1; // RL5
                txCnt_reg <= 16'h0;
                beat_reg  <= 8'h00;
            end
            if (gState_reg == lpgm_pkg::GEN_DONE)
                genDone_reg <= 1'b1; // RL10
            txEna <= {SEGS{sendSop || sendBody}};
            txSop <= {{(SEGS-1){1'b0}}, sendSop}; // RL6
            txEop <= {sendBody && lastBeat, {(SEGS-1){1'b0}}}; // RL8
            txMty <= '0;
            txChan <= {SEGS{11'(txCnt_reg)}};
            txData <= {SEGS{pattern}};
            if (sendSop)
                beat_reg <= 8'h01;
            else if (sendBody)
                beat_reg <= beat_reg + 8'h01;
            if (sendBody && lastBeat)
                txCnt_reg <= txCnt_reg + 16'h1; // RL6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // packet monitor
    lpgm_pkg::lpgm_mon_state_t mState_reg, mState_next;
    logic [15:0] expCnt_reg;
    wire [SEG_W-1:0] expPat = {(SEG_W/16){expCnt_reg}};
    logic [SEGS*2:0] errNow;
    always_comb
    begin
        errNow = '0;
        for (int s = 0; s < SEGS; s++)
        begin
            errNow[s] = rEna[s] && (rData[s*SEG_W +: SEG_W] != expPat); // RL16
            errNow[SEGS+s] = rEna[s] && (rChan[s*11 +: 11] != 11'(expCnt_reg)); // RL16
        end
        errNow[SEGS*2] = |(rMty & {SEGS{4'hf}}) && |rEna; // RL16
    end
    wire rxActive = (mState_reg == lpgm_pkg::MON_RECEIVE);
    wire pktEnd   = rxActive && rEna[SEGS-1] && rEop[SEGS-1];
    wire allRecv  = (rxCnt_reg == 16'(NUM_PKTS));
    always_comb
    begin
        mState_next = mState_reg;
        unique case (mState_reg)
            lpgm_pkg::MON_IDLE:       if (rDone) mState_next = lpgm_pkg::MON_LOCK; // RL13
            lpgm_pkg::MON_LOCK:       mState_next = lpgm_pkg::MON_WAIT_ALIGN;
            lpgm_pkg::MON_WAIT_ALIGN: if (rAlign) mState_next = lpgm_pkg::MON_ENABLE; // RL15
            lpgm_pkg::MON_ENABLE:     mState_next = lpgm_pkg::MON_INIT;
            lpgm_pkg::MON_INIT:       mState_next = lpgm_pkg::MON_RECEIVE;
            lpgm_pkg::MON_RECEIVE:    if (allRecv) mState_next = lpgm_pkg::MON_DONE; // RL17
            lpgm_pkg::MON_DONE:       mState_next = lpgm_pkg::MON_REPORT; // RL18
            lpgm_pkg::MON_REPORT:     mState_next = lpgm_pkg::MON_RESTART; // RL19
            lpgm_pkg::MON_RESTART:    if (restart_req_sync) mState_next = lpgm_pkg::MON_IDLE; // RL20
            default:                  mState_next = lpgm_pkg::MON_IDLE;
        endcase
    end
    logic rxDoneInt_reg;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mState_reg <= lpgm_pkg::MON_IDLE;
            monBusy_reg <= 1'b0;
            monDone_reg <= 1'b0;
            monFail_reg <= 1'b0;
            monLocked_reg <= 1'b0;
            rxDoneInt_reg <= 1'b0;
            ctlRxEnable <= 1'b0;
            errBits_reg <= '0;
            expCnt_reg  <= 16'h0;
            rxCnt_reg   <= 16'h0;
            coreReconfigReset <= 1'b0;
        end
        else
        begin
            mState_reg <= mState_next;
            // software holds this high across port accesses
            coreReconfigReset <= ctrl_reg[`LPGM_CTRL_RECFG]; // RL21
            if (mState_reg == lpgm_pkg::MON_LOCK)
            begin
                monLocked_reg <= 1'b1; // RL14
                monBusy_reg   <= 1'b1;
                monDone_reg   <= 1'b0;
            end
            if (mState_reg == lpgm_pkg::MON_ENABLE)
                ctlRxEnable <= 1'b1; // RL15
            if (mState_reg == lpgm_pkg::MON_INIT)
            begin
                expCnt_reg <= 16'h0;
                rxCnt_reg  <= 16'h0;
            end
            // sticky: only reset clears
            if (rxActive)
                errBits_reg <= errBits_reg | errNow; // RL17
            if (pktEnd)
            begin
                expCnt_reg <= expCnt_reg + 16'h1;
                rxCnt_reg  <= rxCnt_reg + 16'h1;
            end
            if (mState_reg == lpgm_pkg::MON_DONE)
                rxDoneInt_reg <= 1'b1; // RL18
            if (mState_reg == lpgm_pkg::MON_REPORT)
            begin
                monDone_reg <= 1'b1; // RL19
                monFail_reg <= |errBits_reg;
            end
            if (mState_reg == lpgm_pkg::MON_RESTART)
            begin
                monBusy_reg   <= 1'b0; // RL20
                ctlRxEnable   <= 1'b0;
                rxDoneInt_reg <= 1'b0;
            end
        end
    end
endmodule

/* verification/lpgm_core_model.sv */
`timescale 1ns/1ps
module lpgm_core_model #(
    parameter int SEGS  = 4,
    parameter int SEG_W = 128
) (
    // clock, reset and bench control
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  doneIn,
    input  wire logic                  alignIn,
    input  wire logic                  stallEn,
    input  wire logic                  corruptEn,
    // transmit bus from the block
    input  wire logic [SEGS*SEG_W-1:0] txData,
    input  wire logic [SEGS-1:0]       txEna,
    input  wire logic [SEGS-1:0]       txSop,
    input  wire logic [SEGS-1:0]       txEop,
    input  wire logic [SEGS*4-1:0]     txMty,
    input  wire logic [SEGS*11-1:0]    txChan,
    // status and looped-back receive bus
    output logic                       resetDone,
    output logic                       statRxAligned,
    output logic                       txRdyOut,
    output logic      [SEGS*SEG_W-1:0] rxData,
    output logic      [SEGS-1:0]       rxEna,
    output logic      [SEGS-1:0]       rxSop,
    output logic      [SEGS-1:0]       rxEop,
    output logic      [SEGS*4-1:0]     rxMty,
    output logic      [SEGS*11-1:0]    rxChan
);
    logic [4:0] stallCnt;
    wire        beat = |txEna;
    assign resetDone     = doneIn;
    assign statRxAligned = alignIn;
    // back-pressure: ready low for 8 cycles out of every 32
    assign txRdyOut = !(stallEn && stallCnt[4:3] == 2'b11);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stallCnt <= 5'h00;
            {rxData, rxEna, rxSop, rxEop, rxMty, rxChan} <= '0;
        end
        else
        begin
            stallCnt <= stallCnt + 5'h01;
            {rxEna, rxSop, rxEop} <= {txEna, txSop, txEop};
            // idle beats invert the held payload every cycle, so the stale payload returns on every second idle beat
            rxData <= beat ? txData : ~rxData;
            rxChan <= beat ? txChan ^ (corruptEn ? (SEGS*11)'(12'h800) : '0) : ~rxChan;
            rxMty  <= beat ? txMty ^ (corruptEn ? (SEGS*4)'(4'h1) : '0) : ~rxMty;
        end
    end
endmodule

/* verification/lpgm_properties.sv */
`timescale 1ns/1ps
module lpgm_checker #(
    parameter int SEGS  = 4,
    parameter int SEG_W = 128
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // bus answer and core ready
    input  wire logic                  hreadyout,
    input  wire logic                  hresp,
    input  wire logic                  txRdyOut,
    // transmit control and bus
    input  wire logic                  ctlTxEnable,
    input  wire logic [7:0]            ctlTxMubits,
    input  wire logic [11:0]           ctlTxLaneStat,
    input  wire logic                  ctlTxIntfStat,
    input  wire logic [SEGS*SEG_W-1:0] txData,
    input  wire logic [SEGS-1:0]       txEna,
    input  wire logic [SEGS-1:0]       txSop,
    input  wire logic [SEGS-1:0]       txEop,
    input  wire logic [SEGS*4-1:0]     txMty,
    input  wire logic [SEGS*11-1:0]    txChan
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_sop;
        txSop != '0;
    endsequence
    sequence s_eop;
        txEop != '0;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_lock_values: assert property (ctlTxEnable |-> ctlTxMubits == 8'h00 &&
        ctlTxLaneStat == 12'hfff && ctlTxIntfStat) else $error("lock values lost");
    a_tx_needs_en: assert property (txEna != '0 |-> ctlTxEnable)
        else $error("beat sent without transmit enable");
    a_sop_segment: assert property (s_sop |-> txSop == 'h1 && txEna == '1)
        else $error("start marker not on first segment");
    a_eop_segment: assert property (s_eop |-> txEop[SEGS-1] &&
        txEop[SEGS-2:0] == '0 && txSop == '0) else $error("end marker misplaced");
    a_mty_zero: assert property (txEna != '0 |-> txMty == '0)
        else $error("nonzero empty count");
    a_seg_same: assert property (txEna != '0 |-> txChan[10:0] == txChan[21:11] &&
        txData[SEG_W-1:0] == txData[2*SEG_W-1:SEG_W]) else $error("segments disagree");
    a_pkt_body: assert property (s_sop |=> (txSop == '0) [*3])
        else $error("packet restarted too soon");
    a_pkt_closes: assert property (s_sop |-> ##[3:60] s_eop)
        else $error("packet never closed");
    a_stall_halts: assert property (!txRdyOut [*6] |-> txEna == '0)
        else $error("beats sent while held");
endmodule
bind lpgm_packet_gen_mon lpgm_checker #(.SEGS(SEGS), .SEG_W(SEG_W)) u_chk (.clk, .arst_n,
    .hreadyout, .hresp, .txRdyOut, .ctlTxEnable, .ctlTxMubits, .ctlTxLaneStat,
    .ctlTxIntfStat, .txData, .txEna, .txSop, .txEop, .txMty, .txChan);

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "lpgm_defs.svh"
module tb_top;
    localparam int NPK = 3;
    logic clk, arst_n, hsel, hwrite, doneIn, alignIn, stallEn, corruptEn;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic hreadyout, hresp, resetDone, statRxAligned, txRdyOut;
    logic ctlTxEnable, ctlTxIntfStat, coreReconfigReset, ctlRxEnable;
    logic [7:0] ctlTxMubits;
    logic [11:0] ctlTxLaneStat;
    logic [511:0] txData, rxData;
    logic [3:0] txEna, txSop, txEop, rxEna, rxSop, rxEop;
    logic [15:0] txMty, rxMty;
    logic [43:0] txChan, rxChan;
    int failures, cmp_count;
    // control outputs packed for one compare
    wire [23:0] ctl = {ctlTxIntfStat, ctlTxLaneStat, ctlTxMubits, ctlTxEnable,
                       ctlRxEnable, coreReconfigReset};

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    lpgm_packet_gen_mon #(.NUM_PKTS(NPK)) dut (.clk, .arst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .resetDone, .statRxAligned, .txRdyOut, .ctlTxEnable, .ctlTxMubits, .ctlTxLaneStat,
        .ctlTxIntfStat, .coreReconfigReset, .txData, .txEna, .txSop, .txEop, .txMty,
        .txChan, .ctlRxEnable, .rxData, .rxEna, .rxSop, .rxEop, .rxMty, .rxChan);
    lpgm_core_model core (.clk, .arst_n, .doneIn, .alignIn, .stallEn, .corruptEn, .txData,
        .txEna, .txSop, .txEop, .txMty, .txChan, .resetDone, .statRxAligned, .txRdyOut,
        .rxData, .rxEna, .rxSop, .rxEop, .rxMty, .rxChan);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100)
        begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk_pin(rd & m, e);
    endtask
    task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
        int k;
        k = 0;
        do begin bus(1'b0, `LPGM_STATUS_OFS, 32'h0); k++; end
        while ((rd & m) !== v && k < 300);
        if (k >= 300)
        begin
            failures++;
            end_of_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        failures = 0;
        cmp_count = 0;
        {arst_n, hsel, hwrite, doneIn, alignIn, stallEn, corruptEn} = '0;
        {haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        chk_reg(`LPGM_CTRL_OFS, '1, 32'h0);
        chk_reg(`LPGM_ERROR_OFS, '1, 32'h0);
        chk_pin(32'(ctl), 32'h0);
        bus(1'b1, 8'h20, 32'hffffffff);
        chk_reg(8'h20, '1, 32'h0);
        bus(1'b1, `LPGM_CTRL_OFS, 32'h9);
        chk_reg(`LPGM_CTRL_OFS, '1, 32'h8);
        chk_pin(32'(coreReconfigReset), 32'h1);
        bus(1'b1, `LPGM_CTRL_OFS, 32'h0);
        repeat (30) @(posedge clk);
        chk_reg(`LPGM_STATUS_OFS, '1, 32'h0);
        doneIn <= 1'b1;
        repeat (10) @(posedge clk);
        chk_reg(`LPGM_STATUS_OFS, 32'h2d, 32'h25);
        chk_pin(32'(ctl), 32'h00fff800);
        doneIn <= 1'b0;
        stallEn <= 1'b1;
        alignIn <= 1'b1;
        repeat (12) @(posedge clk);
        chk_pin(32'(ctl), 32'h00fff806);
        wait_st(32'h0c, 32'h08);
        chk_reg(`LPGM_STATUS_OFS, 32'h1f, 32'h0a);
        chk_pin(32'(ctl), 32'h00fff804);
        chk_reg(`LPGM_ERROR_OFS, '1, 32'h0);
        chk_reg(`LPGM_TXCNT_OFS, '1, 32'(NPK));
        chk_reg(`LPGM_RXCNT_OFS, '1, 32'(NPK));
        // second run: simplex, restart while both idle, corrupted loopback
        bus(1'b1, `LPGM_CTRL_OFS, 32'h3);
        doneIn <= 1'b1;
        repeat (30) @(posedge clk);
        chk_pin(32'(ctlTxEnable), 32'h0);
        chk_reg(`LPGM_STATUS_OFS, 32'h05, 32'h05);
        corruptEn <= 1'b1;
        doneIn <= 1'b0;
        bus(1'b1, `LPGM_CTRL_OFS, 32'h6);
        wait_st(32'h0c, 32'h08);
        chk_reg(`LPGM_STATUS_OFS, 32'h1f, 32'h1a);
        chk_reg(`LPGM_ERROR_OFS, '1, 32'h120);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        chk_reg(`LPGM_ERROR_OFS, '1, 32'h0);
        end_of_test();
    end
endmodule
